// ==== design/sswpm_lane_mem.sv ====
// Lane-masked storage array with registered read data
`timescale 1ns/10ps
module sswpm_lane_mem #(
    parameter int LANES = 4,
    parameter int LANE_W = 9,
    parameter int WORD_AW = 20
) (
    input wire logic clk,
    sswpm_mem_if.store mem
);
    localparam int DEPTH = 1 << WORD_AW;

    // One array per lane so a masked lane is never touched
    for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
        logic [LANE_W-1:0] store [DEPTH];
        logic [LANE_W-1:0] rdLane;

        // Write only the enabled lane, others keep old contents
        always_ff @(posedge clk) begin
            if (mem.wrEn[lane]) begin
                store[mem.wrAddr] <= mem.wrData[lane*LANE_W +: LANE_W];
            end
        end

        // Read returns contents before a same-cycle write
        always_ff @(posedge clk) begin
            if (mem.rdEn) begin
                rdLane <= store[mem.rdAddr];
            end
        end

        assign mem.rdData[lane*LANE_W +: LANE_W] = rdLane;
    end
endmodule : sswpm_lane_mem

// ==== design/sswpm_write_port.sv ====
// Write port of a separate-port synchronous SRAM with lane masking
//
// Overview of operation
// - Write port select sampled on K rise starts write
// - Select high: write data ignored, nothing stored
// - Data captured on K and complement rising edges
// - Nibble selects gate bits 3:0 and 7:4
// - Nibble selects sampled with their data beat
// - Nibble select high: those four bits unwritten
// - Byte selects gate each 9-bit lane
// - Byte selects sampled on same edge as beat
// - Byte select high: that lane ignored, unwritten
// - Masked lanes keep their previous contents
// - Shared address sampled on K rise when selected
// - Accesses start only on K rising edge
`timescale 1ns/10ps
`include "sswpm_params.svh"

// Pin timing
// All pins are levels sampled by clk, not clocks of their own
// Each pin passes three flops and an agreement filter
// A pin change at edge N shows filtered at edge N+4
// K and K-bar edges are found against the last filtered level
// So the engines act one clock after the filtered edge
// K high and low phases need 8 clocks or more
// Data, address and selects must stand 4 clocks each side
// Shorter phases could let a level vanish in the filter, its edge unseen
// Slow K traded for a plain single-clock design
//
// Write burst
// Filtered K rise with the write select low takes beat 0
// Beats 1 and 3 follow on K-bar rises
// Beat 2 follows on the next K rise
// A K rise mid-burst never opens a second write
// A K-bar rise while idle does nothing
// Each beat raises beatStored for one clock
// Array lanes take the beat one clock after the pulse
// Output writeActive drops with the last beat's pulse
// Next write may open on the K rise after beat 3
// Four beats share one address, beat index below it
//
// Lane masks
// Masks ride the synchroniser beside the data
// So a mask can never slip onto a neighbouring beat
// Masks taken afresh at every beat edge
// A masked lane gets no write enable at all
// Its storage keeps whatever it held before
// Two nibble lanes on the 8-bit variant
// Nine-bit byte lanes on the wider variants
// Byte selects above the last lane are left unused
// Nibble selects unused on the wider variants
//
// Read side
// Plain internal readback, no pin-level output timing
// Filtered K rise with the read select low opens a burst
// One word fetched per clock, well inside a K phase
// Pulse on readValid four clocks in a row
// Data on readData holds between and after the pulses
// Read and write on one K rise share the address
// Beat 0 lands on the clock the read fetches it
// So the read returns the words from before the write
//
// Reset
// Synchronous and active low, port logic only
// The array keeps its contents through reset
// Synchroniser restarts at the idle levels of the pins
// Hold reset 4 clocks so the stages settle
// No K rise at the pins in the first 4 clocks after
//
// Limits
// Address width capped at 24 bits by the elaboration check
// Only burst length four is served by the beat counter
// Data widths other than 8, 9, 18 and 36 are refused

module sswpm_write_port #(
    parameter int DATA_W = `SSWPM_DATA_W,
    parameter int ADDR_W = `SSWPM_ADDR_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic kClock,
    input wire logic kClockBar,
    input wire logic writePortSelect_n,
    input wire logic readPortSelect_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] writeData,
    input wire logic [1:0] nibbleWriteSelect_n,
    input wire logic [3:0] byteWriteSelect_n,
    output logic [DATA_W-1:0] readData,
    output logic readValid,
    output logic writeActive,
    output logic beatStored
);
    // Lane geometry follows the variant's data width
    localparam bit IS_NIBBLE = (DATA_W == `SSWPM_NIBBLE_DATA_W);
    localparam int LANE_W = IS_NIBBLE ? `SSWPM_NIBBLE_W : `SSWPM_BYTE_LANE_W;
    localparam int LANES = DATA_W / LANE_W;
    localparam int BEAT_W = `SSWPM_BEAT_W;
    localparam int WORD_AW = ADDR_W + BEAT_W;

    // Only the four documented widths have a lane map
    if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_width
        $error("sswpm_write_port: DATA_W must be 8, 9, 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
        $error("sswpm_write_port: ADDR_W out of range");
    end
    if (`SSWPM_BURST_BEATS != (1 << BEAT_W)) begin : g_bad_burst
        $error("sswpm_write_port: burst length and beat counter disagree");
    end

    // Every pin input except clk, reset_n and unused selects travels together through one synchroniser
    typedef struct packed {
        logic k;
        logic kBar;
        logic writeSel_n;
        logic readSel_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] laneSel_n;
    } sswpm_pins_t;

    localparam int PIN_W = $bits(sswpm_pins_t);

    // Whole state of the block
    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] sync3;
        logic [PIN_W-1:0] pins;
        logic kPrev;
        logic kBarPrev;
        sswpm_pkg::sswpm_burst_t wState;
        logic [ADDR_W-1:0] wAddr;
        logic [BEAT_W-1:0] wBeat;
        logic [LANES-1:0] wLaneEn;
        logic [WORD_AW-1:0] wWordAddr;
        logic [DATA_W-1:0] wData;
        sswpm_pkg::sswpm_burst_t rState;
        logic [ADDR_W-1:0] rAddr;
        logic [BEAT_W-1:0] rBeat;
        logic rPending;
        logic [DATA_W-1:0] rData;
        logic rValid;
        logic beatPulse;
    } sswpm_state_t;

    // Pins parked at their idle levels so no false edge follows reset
    function automatic sswpm_state_t reset_state();
        sswpm_pins_t idle;
        sswpm_state_t s;
        idle = '0;
        idle.kBar = `SSWPM_KBAR_IDLE;
        idle.writeSel_n = `SSWPM_SEL_IDLE;
        idle.readSel_n = `SSWPM_SEL_IDLE;
        idle.laneSel_n = '1;
        s = '0;
        s.sync1 = idle;
        s.sync2 = idle;
        s.sync3 = idle;
        s.pins = idle;
        s.kBarPrev = `SSWPM_KBAR_IDLE;
        return s;
    endfunction : reset_state

    localparam sswpm_state_t RESET_ST = reset_state();

    sswpm_state_t st;
    sswpm_state_t next_st;
    logic [LANES-1:0] laneSel_n;
    logic [PIN_W-1:0] pinsIn;
    sswpm_pins_t pinNow;
    logic kRise;
    logic kBarRise;
    logic captureEdge;

    sswpm_mem_if #(
        .LANES(LANES),
        .LANE_W(LANE_W),
        .WORD_AW(WORD_AW)
    ) memBus ();

    // Pick the mask pins that this variant really has
    if (IS_NIBBLE) begin : g_nibble
        assign laneSel_n = nibbleWriteSelect_n;
    end else begin : g_byte
        assign laneSel_n = byteWriteSelect_n[LANES-1:0];
    end

    // Masks ride the same path as data, so they stay beat-aligned
    assign pinsIn = {kClock,
                     kClockBar,
                     writePortSelect_n,
                     readPortSelect_n,
                     address,
                     writeData,
                     laneSel_n};
    assign pinNow = sswpm_pins_t'(st.pins);

    // Edges seen on the filtered clock pins
    assign kRise = pinNow.k & ~st.kPrev;
    assign kBarRise = pinNow.kBar & ~st.kBarPrev;

    // Even beats land on K, odd beats on the complement
    assign captureEdge = st.wBeat[0] ? kBarRise : kRise;

    // Next-state logic for synchroniser, write and read engines
    always_comb begin
        next_st = st;

        // Three-stage synchroniser; a bit counts once stages two and three agree
        next_st.sync1 = pinsIn;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.pins = (~(st.sync2 ^ st.sync3) & st.sync3)
                     | ((st.sync2 ^ st.sync3) & st.pins);
        next_st.kPrev = pinNow.k;
        next_st.kBarPrev = pinNow.kBar;

        // Lane enables and the beat strobe are single-cycle
        next_st.wLaneEn = '0;
        next_st.beatPulse = 1'b0;

        // Write engine
        unique case (st.wState)
            sswpm_pkg::SSWPM_IDLE: begin
                // New write only on K; select high leaves data ignored
                if (kRise && !pinNow.writeSel_n) begin
                    next_st.wAddr = pinNow.addr;
                    next_st.wWordAddr = {pinNow.addr, {BEAT_W{1'b0}}};
                    next_st.wData = pinNow.data;
                    next_st.wLaneEn = ~pinNow.laneSel_n;
                    next_st.beatPulse = 1'b1;
                    next_st.wBeat = BEAT_W'(1);
                    next_st.wState = sswpm_pkg::SSWPM_BURST;
                end
            end
            sswpm_pkg::SSWPM_BURST: begin
                // Select on K mid-burst is not a new write
                if (captureEdge) begin
                    next_st.wWordAddr = {st.wAddr, st.wBeat};
                    next_st.wData = pinNow.data;
                    // Fresh mask per beat, high select drops the lane
                    next_st.wLaneEn = ~pinNow.laneSel_n;
                    next_st.beatPulse = 1'b1;
                    next_st.wBeat = BEAT_W'(st.wBeat + 1'b1);
                    if (st.wBeat == `SSWPM_LAST_BEAT) begin
                        next_st.wState = sswpm_pkg::SSWPM_IDLE;
                    end
                end
            end
        endcase

        // Read engine shares the address pins, sampled only on K
        next_st.rPending = (st.rState == sswpm_pkg::SSWPM_BURST);
        next_st.rValid = st.rPending;
        if (st.rPending) begin
            next_st.rData = memBus.rdData;
        end
        unique case (st.rState)
            sswpm_pkg::SSWPM_IDLE: begin
                if (kRise && !pinNow.readSel_n) begin
                    next_st.rAddr = pinNow.addr;
                    next_st.rBeat = '0;
                    next_st.rState = sswpm_pkg::SSWPM_BURST;
                end
            end
            sswpm_pkg::SSWPM_BURST: begin
                // One beat fetched per clock, faster than any K phase
                next_st.rBeat = BEAT_W'(st.rBeat + 1'b1);
                if (st.rBeat == `SSWPM_LAST_BEAT) begin
                    next_st.rState = sswpm_pkg::SSWPM_IDLE;
                end
            end
        endcase
    end

    // State register; the array itself is never reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    // Storage requests come straight from registered state
    assign memBus.wrEn = st.wLaneEn;
    assign memBus.wrAddr = st.wWordAddr;
    assign memBus.wrData = st.wData;
    assign memBus.rdEn = (st.rState == sswpm_pkg::SSWPM_BURST);
    assign memBus.rdAddr = {st.rAddr, st.rBeat};

    // Per-lane storage
    sswpm_lane_mem #(
        .LANES(LANES),
        .LANE_W(LANE_W),
        .WORD_AW(WORD_AW)
    ) u_mem (
        .clk(clk),
        .mem(memBus.store)
    );

    // Outputs, all from flip-flops
    assign readData = st.rData;
    assign readValid = st.rValid;
    assign writeActive = (st.wState == sswpm_pkg::SSWPM_BURST);
    assign beatStored = st.beatPulse;
endmodule : sswpm_write_port

// ==== include/sswpm_mem_if.sv ====
// Connection between the port logic and the lane storage
`timescale 1ns/10ps
interface sswpm_mem_if #(
    parameter int LANES = 4,
    parameter int LANE_W = 9,
    parameter int WORD_AW = 20
);
    logic [LANES-1:0] wrEn;
    logic [WORD_AW-1:0] wrAddr;
    logic [LANES*LANE_W-1:0] wrData;
    logic rdEn;
    logic [WORD_AW-1:0] rdAddr;
    logic [LANES*LANE_W-1:0] rdData;

    // Port logic side
    modport ctrl (
        output wrEn,
        output wrAddr,
        output wrData,
        output rdEn,
        output rdAddr,
        input rdData
    );

    // Storage side
    modport store (
        input wrEn,
        input wrAddr,
        input wrData,
        input rdEn,
        input rdAddr,
        output rdData
    );
endinterface : sswpm_mem_if

// ==== include/sswpm_params.svh ====
// Constants of the synchronous SRAM write port
`ifndef SSWPM_PARAMS_SVH
`define SSWPM_PARAMS_SVH
// Beats in one write or read burst
`define SSWPM_BURST_BEATS 4
// Bits needed to count the beats of a burst
`define SSWPM_BEAT_W 2
// Last beat index of a burst
`define SSWPM_LAST_BEAT 2'h3
// Lane width on the nibble-masked variant
`define SSWPM_NIBBLE_W 4
// Lane width on the byte-masked variants
`define SSWPM_BYTE_LANE_W 9
// Data width of the nibble-masked variant
`define SSWPM_NIBBLE_DATA_W 8
// Default data width and address width
`define SSWPM_DATA_W 36
`define SSWPM_ADDR_W 18
// Synchroniser depth for pin inputs
`define SSWPM_SYNC_STAGES 3
// Idle levels of K-bar and the port selects, loaded at reset
`define SSWPM_KBAR_IDLE 1'b1
`define SSWPM_SEL_IDLE 1'b1
`endif

// ==== include/sswpm_pkg.sv ====
// Types shared by the write and read engines of the write port
package sswpm_pkg;
    // Burst engine state, used for both write and read sides
    typedef enum logic [0:0] {
        SSWPM_IDLE = 1'b0,
        SSWPM_BURST = 1'b1
    } sswpm_burst_t;
endpackage : sswpm_pkg

// ==== verification/sswpm_ctrl_model.sv ====
// Memory controller model driving the port pins
`timescale 1ns/10ps
module sswpm_ctrl_model (
    input wire logic clk,
    output logic kClock,
    output logic kClockBar,
    output logic writePortSelect_n,
    output logic readPortSelect_n,
    output logic [5:0] address,
    output logic [35:0] writeData,
    output logic [1:0] nibbleWriteSelect_n,
    output logic [3:0] byteWriteSelect_n
);
    // Idle pins, all selects off
    initial begin
        kClock = 1'b0;
        kClockBar = 1'b1;
        writePortSelect_n = 1'b1;
        readPortSelect_n = 1'b1;
        address = 6'h00;
        writeData = 36'h0;
        nibbleWriteSelect_n = 2'h3;
        byteWriteSelect_n = 4'hf;
    end
    // Four beats; each phase nine cycles so the synchronisers keep up
    task automatic burst(input logic wr, input logic rd, input logic [5:0] a,
                         input logic [143:0] d, input logic [15:0] m);
        for (int b = 0; b < 4; b++) begin
            @(posedge clk);
            writeData <= d[b*36 +: 36];
            byteWriteSelect_n <= m[b*4 +: 4];
            nibbleWriteSelect_n <= m[b*4 +: 2];
            if (b == 0) begin
                writePortSelect_n <= ~wr;
                readPortSelect_n <= ~rd;
                address <= a;
            end
            repeat (4) @(posedge clk);
            kClock <= ~b[0];
            kClockBar <= b[0];
            repeat (4) @(posedge clk);
            writePortSelect_n <= 1'b1;
            readPortSelect_n <= 1'b1;
            address <= ~a; // Stale address must not be reused
        end
        writeData <= ~writeData;
    endtask : burst
endmodule : sswpm_ctrl_model

// ==== verification/sswpm_write_port_monitor.sv ====
// Port checker for the lane-masked write port
`timescale 1ns/10ps
module sswpm_write_port_monitor #(
    parameter int DATA_W = 36
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic kClock,
    input wire logic kClockBar,
    input wire logic writePortSelect_n,
    input wire logic readPortSelect_n,
    input wire logic [DATA_W-1:0] readData,
    input wire logic readValid,
    input wire logic writeActive,
    input wire logic beatStored
);
    // Pin edges are seen a cycle late here, so windows allow the slack
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_wgo;
        $rose(kClock) && !writePortSelect_n && !writeActive |-> ##[2:8] beatStored; endproperty
    a_wgo: assert property (p_wgo) else $error("write not started");
    property p_wdes;
        $rose(kClock) && writePortSelect_n && !writeActive |-> ##1 !beatStored [*8]; endproperty
    a_wdes: assert property (p_wdes) else $error("beat stored while deselected");
    property p_kbi;
        $rose(kClockBar) && !writeActive |-> ##1 !beatStored [*8]; endproperty
    a_kbi: assert property (p_kbi) else $error("burst started on K-bar");
    property p_act;
        $rose(writeActive) |-> beatStored; endproperty
    a_act: assert property (p_act) else $error("active without beat");
    property p_pls;
        beatStored |=> !beatStored; endproperty
    a_pls: assert property (p_pls) else $error("beat pulse too long");
    property p_rgo;
        $rose(kClock) && !readPortSelect_n && !readValid |-> ##[3:9] readValid; endproperty
    a_rgo: assert property (p_rgo) else $error("read not started");
    property p_rd4;
        $rose(readValid) |-> readValid [*4] ##1 !readValid; endproperty
    a_rd4: assert property (p_rd4) else $error("read burst not four beats");
    property p_rhold;
        !readValid |-> $stable(readData); endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved while idle");
    c_wr: cover property ($rose(writeActive));
    c_rd: cover property ($rose(readValid));
    c_des: cover property ($rose(kClock) && writePortSelect_n && !writeActive);
endmodule : sswpm_write_port_monitor

bind sswpm_write_port sswpm_write_port_monitor #(.DATA_W(DATA_W)) u_mon (
    .clk(clk), .reset_n(reset_n), .kClock(kClock), .kClockBar(kClockBar),
    .writePortSelect_n(writePortSelect_n), .readPortSelect_n(readPortSelect_n),
    .readData(readData), .readValid(readValid), .writeActive(writeActive),
    .beatStored(beatStored));

// ==== verification/sswpm_write_port_tb.sv ====
// Self-checking bench for the lane-masked write port
`timescale 1ns/10ps
module sswpm_write_port_tb;
    logic clk;
    logic reset_n;
    logic kClock;
    logic kClockBar;
    logic writePortSelect_n;
    logic readPortSelect_n;
    logic [5:0] address;
    logic [35:0] writeData;
    logic [1:0] nibbleWriteSelect_n;
    logic [3:0] byteWriteSelect_n;
    logic [35:0] readData;
    logic readValid;
    logic writeActive;
    logic beatStored;
    logic [7:0] readData8;
    logic readValid8;
    logic writeActive8;
    logic beatStored8;
    logic [35:0] mem [256];
    logic [35:0] expQ [$];
    logic [7:0] mem8 [256];
    logic [35:0] expQ8 [$];
    int beats8;
    int errors;
    int check_count;
    int beats;
    int expBeats;
    int cycles;

    sswpm_ctrl_model u_ctrl (.clk(clk), .kClock(kClock), .kClockBar(kClockBar),
        .writePortSelect_n(writePortSelect_n), .readPortSelect_n(readPortSelect_n),
        .address(address), .writeData(writeData),
        .nibbleWriteSelect_n(nibbleWriteSelect_n), .byteWriteSelect_n(byteWriteSelect_n));
    sswpm_write_port #(.DATA_W(36), .ADDR_W(6)) DUT (.clk(clk), .reset_n(reset_n),
        .kClock(kClock), .kClockBar(kClockBar), .writePortSelect_n(writePortSelect_n),
        .readPortSelect_n(readPortSelect_n), .address(address), .writeData(writeData),
        .nibbleWriteSelect_n(nibbleWriteSelect_n), .byteWriteSelect_n(byteWriteSelect_n),
        .readData(readData), .readValid(readValid), .writeActive(writeActive),
        .beatStored(beatStored));
    // Nibble-masked variant on the same pins, low byte of the data
    sswpm_write_port #(.DATA_W(8), .ADDR_W(6)) DUT_nibble (.clk(clk), .reset_n(reset_n),
        .kClock(kClock), .kClockBar(kClockBar), .writePortSelect_n(writePortSelect_n),
        .readPortSelect_n(readPortSelect_n), .address(address), .writeData(writeData[7:0]),
        .nibbleWriteSelect_n(nibbleWriteSelect_n), .byteWriteSelect_n(byteWriteSelect_n),
        .readData(readData8), .readValid(readValid8), .writeActive(writeActive8),
        .beatStored(beatStored8));

    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check_val(input string name, input logic [35:0] exp, input logic [35:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic close_out();
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Only lanes with a low select take new data
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] m);
        for (int l = 0; l < 4; l++) begin
            if (!m[l]) o[l*9 +: 9] = n[l*9 +: 9];
        end
        return o;
    endfunction : merge

    // Nibble lanes: select bit 0 for bits 3:0, bit 1 for bits 7:4
    function automatic logic [7:0] merge8(logic [7:0] o, logic [7:0] n, logic [1:0] m);
        for (int l = 0; l < 2; l++) begin
            if (!m[l]) o[l*4 +: 4] = n[l*4 +: 4];
        end
        return o;
    endfunction : merge8

    function automatic logic [143:0] rnd();
        logic [159:0] r;
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        return r[143:0];
    endfunction : rnd

    // Read expects old contents, so queue before the write lands
    task automatic run(input logic wr, input logic rd, input logic [5:0] a,
                       input logic [143:0] d, input logic [15:0] m);
        for (int b = 0; b < 4; b++) begin
            if (rd) expQ.push_back(mem[{a, b[1:0]}]);
            if (wr) mem[{a, b[1:0]}] = merge(mem[{a, b[1:0]}], d[b*36 +: 36], m[b*4 +: 4]);
            if (rd) expQ8.push_back(36'(mem8[{a, b[1:0]}]));
            if (wr) mem8[{a, b[1:0]}] = merge8(mem8[{a, b[1:0]}], d[b*36 +: 8], m[b*4 +: 2]);
        end
        if (wr) expBeats += 4;
        u_ctrl.burst(wr, rd, a, d, m);
    endtask : run

    // Port observation and hang guard
    always @(posedge clk) begin
        cycles++;
        if (beatStored === 1'b1) beats++;
        if (readValid === 1'b1)
            check_val("readData", expQ.size() ? expQ.pop_front() : 'x, readData);
        if (beatStored8 === 1'b1) beats8++;
        if (readValid8 === 1'b1)
            check_val("readData8", expQ8.size() ? expQ8.pop_front() : 'x, 36'(readData8));
        if (cycles == 4000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        reset_n = 1'b0;
        void'($urandom(85));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 0; a < 4; a++) run(1'b1, 1'b0, 6'(a), rnd(), 16'h0000);
        run(1'b1, 1'b1, 6'h02, rnd(), 16'hffff);
        run(1'b0, 1'b1, 6'h01, rnd(), 16'h0000);
        run(1'b1, 1'b0, 6'h03, rnd(), 16'h5a0f);
        for (int i = 0; i < 16; i++)
            run(1'($urandom), 1'($urandom), 6'($urandom_range(3)), rnd(), 16'($urandom));
        for (int a = 0; a < 4; a++) run(1'b0, 1'b1, 6'(a), rnd(), 16'h0000);
        repeat (10) @(posedge clk);
        check_val("beats", 36'(expBeats), 36'(beats));
        check_val("beats8", 36'(expBeats), 36'(beats8));
        check_val("readsLeft", 36'h0, 36'(expQ.size() + expQ8.size()));
        close_out();
    end
endmodule : sswpm_write_port_tb
